// ### src/sysctl_pkg.sv
// Constants for the system control low-bit register bank
package sysctl_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int REG_ADDR_W = 4;
    localparam logic [REG_ADDR_W-1:0] SYSTEM_CONTROL_OFFSET = 4'h0;
    localparam int DATA_W = 8;
    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int NMI_EDGE_POLARITY_SELECT_POS = 2;
    localparam int SHARED_WINDOW_SELECT_POS = 1;
    localparam int ONCHIP_RAM_ENABLE_POS = 0;
    localparam int CTRL_W = 3;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h1;
    // ------------------------------------------------------------
    // Shared peripheral windows (low 16 address bits)
    // ------------------------------------------------------------
    localparam int PERIPH_ADDR_W = 16;
    localparam logic [15:0] WINDOW_A_LO = 16'hfff0;
    localparam logic [15:0] WINDOW_A_HI = 16'hfff7;
    localparam logic [15:0] WINDOW_B_LO = 16'hfffc;
    localparam logic [15:0] WINDOW_B_HI = 16'hffff;
endpackage

// ### src/nmi_edge_detect.sv
// Selectable edge detector for the non-maskable interrupt input
`timescale 1ns/1ps
`default_nettype none
module nmi_edge_detect (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic nmi_in,
    input wire logic rising_sel,
    output logic nmi_request
);
    typedef struct packed {
        logic prev;
        logic req;
    } edge_state_t;

    edge_state_t s_q;
    edge_state_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.prev = nmi_in;
        if (rising_sel) begin
            s_d.req = nmi_in & ~s_q.prev;
        end else begin
            s_d.req = ~nmi_in & s_q.prev;
        end
    end

    // Previous level starts high so a high input at release is no edge
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q <= '{prev: 1'b1, req: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign nmi_request = s_q.req;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_nmi_fall_edge:
    assert property ($fell(nmi_in) && !rising_sel |=> nmi_request)
        else $error("falling edge missed");
    a_nmi_rise_edge:
    assert property ($rose(nmi_in) && rising_sel |=> nmi_request)
        else $error("rising edge missed");
    a_nmi_no_spurious:
    assert property ($stable(nmi_in) |=> !nmi_request)
        else $error("request without an edge");
endmodule
`default_nettype wire

// ### src/system_control_low_bits.sv
// System control register low bits: NMI edge, window select, RAM enable
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Edge bit 0 gives NMI request on falling edge, 1 on rising edge.
// - Window bit 0 maps shared ranges to timer and timer-link registers.
// - Window bit 1 maps shared ranges to host and keypad registers.
// - RAM enable bit 0 disables on-chip RAM, 1 enables it.
// - RAM enable returns to 1 as soon as reset is asserted.
// - Only one register group is visible in the shared ranges at once.
module system_control_low_bits #(
    parameter int ADDR_W = sysctl_pkg::REG_ADDR_W
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [sysctl_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [sysctl_pkg::DATA_W-1:0] reg_rdata,
    input wire logic nmi_in,
    output logic nmi_request,
    input wire logic [sysctl_pkg::PERIPH_ADDR_W-1:0] periph_addr,
    input wire logic periph_access,
    output logic timer_group_select,
    output logic host_group_select,
    output logic onchip_ram_enable,
    output logic nmi_edge_polarity_select,
    output logic shared_window_select
);
    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (ADDR_W < sysctl_pkg::REG_ADDR_W) begin : g_bad_addr_w
        $error("ADDR_W too narrow for the register offset");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [sysctl_pkg::CTRL_W-1:0] ctrl;
        logic [sysctl_pkg::DATA_W-1:0] rdata;
        logic timer_sel;
        logic host_sel;
    } ctrl_state_t;

    ctrl_state_t s_q;
    ctrl_state_t s_d;
    logic reg_hit;
    logic in_window;

    assign reg_hit = (reg_addr == ADDR_W'(sysctl_pkg::SYSTEM_CONTROL_OFFSET));
    assign in_window =
        ((periph_addr >= sysctl_pkg::WINDOW_A_LO) &&
         (periph_addr <= sysctl_pkg::WINDOW_A_HI)) ||
        ((periph_addr >= sysctl_pkg::WINDOW_B_LO) &&
         (periph_addr <= sysctl_pkg::WINDOW_B_HI));

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.rdata = '0;
        if (reg_we && reg_hit) begin
            s_d.ctrl = reg_wdata[sysctl_pkg::CTRL_W-1:0];
        end
        if (reg_re && reg_hit) begin
            s_d.rdata = {{(sysctl_pkg::DATA_W - sysctl_pkg::CTRL_W){1'b0}},
                         s_q.ctrl};
        end
        // Decode uses the select value in force during the access
        s_d.timer_sel = periph_access && in_window &&
            !s_q.ctrl[sysctl_pkg::SHARED_WINDOW_SELECT_POS];
        s_d.host_sel = periph_access && in_window &&
            s_q.ctrl[sysctl_pkg::SHARED_WINDOW_SELECT_POS];
    end

    // Async reset loads the documented initial values, RAM enabled
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q.ctrl <= sysctl_pkg::CTRL_RESET;
            s_q.rdata <= '0;
            s_q.timer_sel <= 1'b0;
            s_q.host_sel <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata = s_q.rdata;
    assign timer_group_select = s_q.timer_sel;
    assign host_group_select = s_q.host_sel;
    assign onchip_ram_enable =
        s_q.ctrl[sysctl_pkg::ONCHIP_RAM_ENABLE_POS];
    assign nmi_edge_polarity_select =
        s_q.ctrl[sysctl_pkg::NMI_EDGE_POLARITY_SELECT_POS];
    assign shared_window_select =
        s_q.ctrl[sysctl_pkg::SHARED_WINDOW_SELECT_POS];

    nmi_edge_detect u_nmi_edge (
        .core_clk(core_clk),
        .rst(rst),
        .nmi_in(nmi_in),
        .rising_sel(nmi_edge_polarity_select),
        .nmi_request(nmi_request)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // Register checks
    // ------------------------------------------------------------
    a_ram_enable_write:
    assert property (reg_we && reg_hit
                     |=> onchip_ram_enable == $past(reg_wdata[0]))
        else $error("RAM enable does not follow write");

    a_ram_enable_clear:
    assert property (reg_we && reg_hit && !reg_wdata[0]
                     |=> !onchip_ram_enable)
        else $error("RAM still enabled after clearing");

    a_edge_bit_write:
    assert property (reg_we && reg_hit
                     |=> nmi_edge_polarity_select == $past(reg_wdata[2]))
        else $error("edge select does not follow write");

    a_window_bit_write:
    assert property (reg_we && reg_hit
                     |=> shared_window_select == $past(reg_wdata[1]))
        else $error("window select does not follow write");

    a_ctrl_hold:
    assert property (!(reg_we && reg_hit) |=> $stable(s_q.ctrl))
        else $error("control bits changed without a write");

    a_write_refused:
    assert property (reg_we && !reg_hit |=> $stable(s_q.ctrl))
        else $error("write to another address changed the bits");

    a_read_back_value:
    assert property (reg_re && reg_hit |=> reg_rdata ==
                     {5'h00, $past(s_q.ctrl)})
        else $error("read data differs from register");

    a_write_then_read:
    assert property (reg_we && reg_hit ##1 reg_re && reg_hit
                     |=> reg_rdata[2:0] == $past(reg_wdata[2:0], 2))
        else $error("written value not read back");

    a_rdata_idle:
    assert property (!(reg_re && reg_hit) |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");

    a_rdata_upper_zero:
    assert property (reg_rdata[7:3] == 5'h00)
        else $error("unused read data bits not zero");

    // ------------------------------------------------------------
    // Shared window checks
    // ------------------------------------------------------------
    a_timer_window_map:
    assert property (periph_access && in_window && !shared_window_select
                     |=> timer_group_select && !host_group_select)
        else $error("timer group not selected");

    a_host_window_map:
    assert property (periph_access && in_window && shared_window_select
                     |=> host_group_select && !timer_group_select)
        else $error("host group not selected");

    a_timer_select_cause:
    assert property (timer_group_select |-> $past(periph_access) &&
                     $past(in_window) && !$past(shared_window_select))
        else $error("timer group selected without cause");

    a_host_select_cause:
    assert property (host_group_select |-> $past(periph_access) &&
                     $past(in_window) && $past(shared_window_select))
        else $error("host group selected without cause");

    a_one_group_only:
    assert property (!(timer_group_select && host_group_select))
        else $error("both register groups selected");

    a_outside_window:
    assert property (!in_window
                     |=> !timer_group_select && !host_group_select)
        else $error("group selected outside the windows");

    a_no_access_idle:
    assert property (!periph_access
                     |=> !timer_group_select && !host_group_select)
        else $error("group selected without an access");

    a_decode_before_write:
    assert property (reg_we && reg_hit && periph_access && in_window
                     |=> timer_group_select == !$past(shared_window_select))
        else $error("decode used the bit being written");

    // ------------------------------------------------------------
    // Reset checks
    // ------------------------------------------------------------
    a_ram_after_reset:
    assert property ($past(rst) |-> onchip_ram_enable &&
                     !nmi_edge_polarity_select && !shared_window_select)
        else $error("wrong value after reset release");

    a_outputs_after_reset:
    assert property ($past(rst) |-> !nmi_request && !timer_group_select &&
                     !host_group_select && reg_rdata == 8'h00)
        else $error("outputs not idle after reset release");
endmodule
`default_nettype wire

// ### dv/tb_system_control_low_bits.sv
// Self-checking bench for the system control low-bit register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(s, e, g) begin n_compared++; if ((g) !== (e)) begin \
    n_errors++; $display("Error %s expected %h seen %h", s, e, g); end end
module tb_system_control_low_bits;
    logic core_clk = 0, rst = 1, reg_we = 0, reg_re = 0, nmi_in = 1;
    logic periph_access = 0, nmi_request, timer_group_select, re_seen;
    logic host_group_select, onchip_ram_enable, prev = 1;
    logic nmi_edge_polarity_select, shared_window_select;
    logic [3:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, reg_rdata;
    logic [15:0] periph_addr = 0;
    logic [2:0] m = 3'h1, m_vis, seen_ctrl;
    logic [11:0] q[$];
    logic [31:0] r;
    logic [15:0] tab[7] = '{16'hffef, 16'hfff0, 16'hfff7, 16'hfff8,
        16'hfffb, 16'hfffc, 16'hffff};
    int n_errors = 0, n_compared = 0, seed = 46126;
    assign seen_ctrl = {nmi_edge_polarity_select, shared_window_select,
        onchip_ram_enable};
    always #2 core_clk = ~core_clk;
    system_control_low_bits uut (.core_clk(core_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
        .reg_re(reg_re), .reg_rdata(reg_rdata), .nmi_in(nmi_in),
        .nmi_request(nmi_request), .periph_addr(periph_addr),
        .periph_access(periph_access),
        .timer_group_select(timer_group_select),
        .host_group_select(host_group_select),
        .onchip_ram_enable(onchip_ram_enable),
        .nmi_edge_polarity_select(nmi_edge_polarity_select),
        .shared_window_select(shared_window_select));
    // ------------------------------------------------------------
    // Driver: one call drives every input but rst for one cycle
    // ------------------------------------------------------------
    function automatic logic in_win(input logic [15:0] a);
        return (a >= 16'hfff0 && a <= 16'hfff7) || a >= 16'hfffc;
    endfunction
    task automatic cyc(input logic we, re, input logic [3:0] a,
        input logic [7:0] d, input logic acc, input logic [15:0] pa,
        input logic n);
        @(posedge core_clk);
        reg_we <= we;
        reg_re <= re;
        reg_addr <= a;
        reg_wdata <= d;
        periph_access <= acc;
        periph_addr <= pa;
        nmi_in <= n;
        if (re) q.push_back({4'h1, (a == 0) ? {5'h0, m} : 8'h0});
        if (n != prev && n == m[2]) q.push_back(12'h200);
        if (acc && in_win(pa)) q.push_back(m[1] ? 12'h400 : 12'h300);
        if (we && a == 0) m <= d[2:0];
        prev <= n;
    endtask
    task automatic do_reset(input int n);
        @(posedge core_clk);
        rst <= 1;
        reg_we <= 0;
        reg_re <= 0;
        periph_access <= 0;
        nmi_in <= 1;
        m <= 3'h1;
        prev <= 1;
        repeat (n) @(posedge core_clk);
        rst <= 0;
    endtask
    // ------------------------------------------------------------
    // Monitor: takes the oldest note whenever a result appears
    // ------------------------------------------------------------
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            re_seen <= 0;
            m_vis <= 3'h1;
        end else begin
            re_seen <= reg_re;
            m_vis <= m;
        end
    end
    task automatic take(input logic [3:0] k, input logic [7:0] v);
        logic [11:0] e;
        e = q.size() ? q.pop_front() : 12'hfff;
        `CHK("result", e, {k, v})
    endtask
    always @(negedge core_clk) begin
        if (!rst) begin
            if (re_seen) take(4'h1, reg_rdata);
            else `CHK("rdata", 8'h0, reg_rdata)
            if (nmi_request) take(4'h2, 8'h0);
            if (timer_group_select) take(4'h3, 8'h0);
            if (host_group_select) take(4'h4, 8'h0);
            `CHK("ctrl", m_vis, seen_ctrl)
        end
    end
    task automatic give_verdict;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #20000;
        n_errors++;
        give_verdict();
    end
    initial begin
        do_reset(4);
        cyc(0, 1, 0, 0, 0, 0, 1);
        cyc(1, 0, 0, 8'h06, 0, 0, 1);
        cyc(0, 1, 0, 0, 0, 0, 0);
        cyc(1, 0, 0, 8'hff, 0, 0, 1);
        cyc(0, 1, 0, 0, 0, 0, 1);
        cyc(1, 0, 4'h5, 8'h00, 0, 0, 1);
        cyc(0, 1, 4'h5, 0, 0, 0, 1);
        for (int w = 0; w < 2; w++) begin
            cyc(1, 0, 0, {6'h0, w[0], 1'b1}, 0, 0, 1);
            foreach (tab[i]) cyc(0, 0, 0, 0, 1, tab[i], 1);
        end
        repeat (400) begin
            r = $random(seed);
            cyc(r[0], r[1] & ~r[0], r[6] ? r[5:2] : 4'h0, r[15:8], r[16],
                r[17] ? {12'hfff, r[21:18]} : r[31:16], r[22]);
        end
        cyc(1, 0, 0, 8'h06, 0, 0, 1);
        repeat (3) cyc(0, 0, 0, 0, 0, 0, 1);
        do_reset(2);
        cyc(0, 1, 0, 0, 0, 0, 1);
        repeat (3) cyc(0, 0, 0, 0, 0, 0, 1);
        `CHK("queue", 0, q.size())
        give_verdict();
    end
endmodule
`default_nettype wire
